// ==== logic/sst_consts.svh ====
// register offsets, field positions and reset values of the slave transmitter
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
`define SST_OFF_RXDATA   12'h000
`define SST_OFF_TXDATA   12'h004
`define SST_OFF_BAUDLO   12'h008
`define SST_OFF_CTRL     12'h00C
`define SST_OFF_STATUS   12'h010
`define SST_OFF_IRQEN    12'h014
`define SST_OFF_SLEEP    12'h018
`define SST_CTRL_SYNC    0
`define SST_CTRL_PORTEN  1
`define SST_CTRL_CLOCK_SOURCE_SELECT    2
`define SST_CTRL_CONTINUOUS_RX_ENABLE    3
`define SST_CTRL_SINGLE_RX_ENABLE    4
`define SST_CTRL_TX9     5
`define SST_CTRL_TX_ENABLE_BIT    6
`define SST_CTRL_TX_NINTH_BIT    7
`define SST_CTRL_ANALOG_PIN_SELECT   8
`define SST_IRQ_TXIE     0
`define SST_IRQ_PERIPHERAL_IRQ_ENABLE     1
`define SST_IRQ_GIE      2
`define SST_RESET_BYTE   8'h00
`define SST_CTRL_RESET   9'h000
`endif

// ==== logic/sst_pkg.sv ====
// types of the slave transmitter
package sst_pkg;
	typedef enum logic [1:0] {
		SST_IDLE  = 2'b00,
		SST_SHIFT = 2'b01
	} sst_state_type;
endpackage : sst_pkg

// ==== logic/sst_tx.sv ====
// synchronous slave transmitter with apb register file
// Functional notes
// - queued first word shifts at once in sleep
// - second word waits, empty flag stays clear
// - after first, load second, then set flag
// - flag with enables wakes device from sleep
// - slave shifting matches master apart from clock
// - sync, port enable set, clock source cleared
// - both receive enables clear for transmit
// - analog select on clock pin cleared
// - nine bit select gives nine bit characters
// - ninth bit field sent as msb
// - send only while transmit enable set
// - holding register write starts transmission
// - flag reaches irq only when all enabled
// - receive data read only, resets zero
// - receive data single register, replaced on each valid char
// - holding register double buffered, resets zero
// - low baud divisor read write, resets zero
// - divisor write resets baud counter
// - cleared clock source: take external clock
`timescale 1ns/1ps
`default_nettype none
`include "sst_consts.svh"
module sst_tx
	import sst_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        shift_timing_pin,
	input  wire logic        rx_char_valid,
	input  wire logic [8:0]  rx_char,
	output logic             tx_data_out,
	output logic             tx_data_oe,
	output logic             wake_out,
	output logic             irq_out,
	output logic [7:0]       baud_count
);
	logic [7:0]    tx_holding_reg;
	logic          hold_ninth;
	logic          hold_full;
	logic [8:0]    tx_shift_reg;
	logic [3:0]    bits_left;
	sst_state_type state;
	logic [7:0]    rx_data_reg;
	logic          rx_ninth_bit;
	logic [7:0]    baud_divisor_low;
	logic [8:0]    ctrl;
	logic [2:0]    irq_ctrl;
	logic          sleep_mode;
	logic          clk_prev;
	logic          tx_buffer_empty_flag;

	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire hit_rx   = (paddr == `SST_OFF_RXDATA);
	wire hit_tx   = (paddr == `SST_OFF_TXDATA);
	wire hit_baud = (paddr == `SST_OFF_BAUDLO);
	wire hit_ctrl = (paddr == `SST_OFF_CTRL);
	wire hit_stat = (paddr == `SST_OFF_STATUS);
	wire hit_irq  = (paddr == `SST_OFF_IRQEN);
	wire hit_slp  = (paddr == `SST_OFF_SLEEP);
	wire mapped   = hit_rx | hit_tx | hit_baud | hit_ctrl | hit_stat |
		hit_irq | hit_slp;

	// slave transmit mode: sync on, port on, external clock, no receive
	wire slave_tx = ctrl[`SST_CTRL_SYNC] & ctrl[`SST_CTRL_PORTEN] &
		~ctrl[`SST_CTRL_CLOCK_SOURCE_SELECT] &
		~ctrl[`SST_CTRL_CONTINUOUS_RX_ENABLE] & ~ctrl[`SST_CTRL_SINGLE_RX_ENABLE] &
		~ctrl[`SST_CTRL_ANALOG_PIN_SELECT];
	wire tx_on    = slave_tx & ctrl[`SST_CTRL_TX_ENABLE_BIT];
	wire nine     = ctrl[`SST_CTRL_TX9];
	// data changes on the falling master edge, the master samples on rise
	wire fall     = clk_prev & ~shift_timing_pin;
	wire wr_tx    = wr & hit_tx;
	wire last_bit = (state == SST_SHIFT) && fall && (bits_left == 4'h1);
	wire load     = tx_on && hold_full &&
		((state == SST_IDLE) || last_bit);
	wire irq_gate = tx_buffer_empty_flag & irq_ctrl[`SST_IRQ_TXIE] &
		irq_ctrl[`SST_IRQ_PERIPHERAL_IRQ_ENABLE];

	assign pready      = 1'b1;
	assign pslverr     = acc & ~mapped;
	assign tx_data_out = tx_shift_reg[0];
	assign tx_data_oe  = tx_on & (state == SST_SHIFT);
	assign tx_buffer_empty_flag = ~hold_full;
	assign irq_out     = irq_gate & irq_ctrl[`SST_IRQ_GIE];
	assign wake_out    = sleep_mode & irq_gate;

	wire [31:0] rd_mux =
		hit_rx   ? {24'h000000, rx_data_reg} :
		hit_tx   ? {24'h000000, tx_holding_reg} :
		hit_baud ? {24'h000000, baud_divisor_low} :
		hit_ctrl ? {23'h000000, ctrl} :
		hit_stat ? {28'h0000000, rx_ninth_bit, (state == SST_SHIFT),
			hold_full, tx_buffer_empty_flag} :
		hit_irq  ? {29'h00000000, irq_ctrl} :
		hit_slp  ? {31'h00000000, sleep_mode} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl       <= `SST_CTRL_RESET;
			irq_ctrl   <= 3'h0;
			sleep_mode <= 1'b0;
		end else begin
			if (wr & hit_ctrl)
				ctrl <= pwdata[8:0];
			if (wr & hit_irq)
				irq_ctrl <= pwdata[2:0];
			if (wr & hit_slp)
				sleep_mode <= pwdata[0];
			else if (wake_out)
				sleep_mode <= 1'b0;
		end
	end

	// holding register accepts a write at any time; the write wins the
	// same-cycle load so nothing is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_reg <= `SST_RESET_BYTE;
			hold_ninth     <= 1'b0;
			hold_full      <= 1'b0;
		end else if (wr_tx) begin
			tx_holding_reg <= pwdata[7:0];
			hold_ninth     <= ctrl[`SST_CTRL_TX_NINTH_BIT];
			hold_full      <= 1'b1;
		end else if (load) begin
			hold_full <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			clk_prev <= 1'b0;
		else
			clk_prev <= shift_timing_pin;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_shift_reg <= 9'h000;
			bits_left    <= 4'h0;
			state        <= SST_IDLE;
		end else if (!tx_on) begin
			state     <= SST_IDLE;
			bits_left <= 4'h0;
		end else if (load) begin
			tx_shift_reg <= {hold_ninth, tx_holding_reg};
			bits_left    <= nine ? 4'h9 : 4'h8;
			state        <= SST_SHIFT;
		end else if (state == SST_SHIFT && fall) begin
			tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
			bits_left    <= bits_left - 4'h1;
			if (bits_left == 4'h1)
				state <= SST_IDLE;
		end
	end

	// receive buffer keeps the last character while the next arrives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_reg  <= `SST_RESET_BYTE;
			rx_ninth_bit <= 1'b0;
		end else if (rx_char_valid) begin
			rx_data_reg  <= rx_char[7:0];
			rx_ninth_bit <= rx_char[8];
		end
	end

	// counter only runs in master mode; kept for divisor behaviour
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor_low <= `SST_RESET_BYTE;
			baud_count       <= 8'h00;
		end else if (wr & hit_baud) begin
			baud_divisor_low <= pwdata[7:0];
			baud_count       <= 8'h00;
		end else if (ctrl[`SST_CTRL_CLOCK_SOURCE_SELECT]) begin
			if (baud_count >= baud_divisor_low)
				baud_count <= 8'h00;
			else
				baud_count <= baud_count + 8'h01;
		end
	end
endmodule : sst_tx
`default_nettype wire

// ==== verif/sst_tx_asserts.sv ====
// port checks for the slave transmitter
`timescale 1ns/1ps
`default_nettype none
module sst_tx_asserts (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	shift_timing_pin,
	input wire logic	tx_data_out,
	input wire logic	tx_data_oe,
	input wire logic [7:0]	baud_count
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic wbrg = acc && pwrite && paddr == 12'h008;
	// pin high three samples: no fall pending
	sequence s_hi; shift_timing_pin [*3] ##0 tx_data_oe; endsequence
	property p_rdy; psel |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready low");
	property p_err; pslverr |-> acc; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unm; acc && paddr > 12'h018 |-> pslverr; endproperty
	a_unm: assert property (p_unm) else $error("unmapped ok");
	property p_map;
		acc && paddr <= 12'h018 && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	a_map: assert property (p_map) else $error("mapped error");
	property p_brg; wbrg |=> baud_count == 8'h00; endproperty
	a_brg: assert property (p_brg) else $error("count kept");
	property p_prd; $changed(prdata) |-> $past(psel && !penable); endproperty
	a_prd: assert property (p_prd) else $error("read data moved");
	property p_oe; s_hi |=> tx_data_oe; endproperty
	a_oe: assert property (p_oe) else $error("early stop");
	property p_dat; s_hi |=> $stable(tx_data_out); endproperty
	a_dat: assert property (p_dat) else $error("bit moved");
	c_tx: cover property ($fell(tx_data_oe));
	c_err: cover property (pslverr);
	c_brg: cover property (wbrg);
endmodule : sst_tx_asserts
bind sst_tx sst_tx_asserts i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.shift_timing_pin(shift_timing_pin), .tx_data_out(tx_data_out),
	.tx_data_oe(tx_data_oe), .baud_count(baud_count));
`default_nettype wire

// ==== verif/sst_master.sv ====
// external master driving the shift clock
`timescale 1ns/1ps
`default_nettype none
module sst_master (
	input wire logic	pclk,
	input wire logic	tx_data_out,
	output logic	shift_timing_pin
);
	logic [8:0]	got;
	// idle low, still between frames
	initial shift_timing_pin = 1'b0;
	task automatic xfer(input int n, input int h);
		got = 9'h000;
		for (int i = 0; i < n; i++) begin
			repeat (h) @(posedge pclk);
			shift_timing_pin <= 1'b1;
			got[i] = tx_data_out;
			repeat (h) @(posedge pclk);
			shift_timing_pin <= 1'b0;
		end
		repeat (4) @(posedge pclk);
	endtask : xfer
endmodule : sst_master
`default_nettype wire

// ==== verif/sst_tx_bench.sv ====
// bench for the slave transmitter
`timescale 1ns/1ps
`default_nettype none
module sst_tx_bench;
	logic	pclk, presetn, psel, penable, pwrite, rxv, stp, woke, er;
	logic	pready, pslverr, tdo, toe, wake, irq;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [8:0]	rxc;
	logic [7:0]	bc;
	int	bad_count, num_checks;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (wake === 1'b1) woke <= 1'b1;
	sst_tx i_sst_tx (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shift_timing_pin(stp), .rx_char_valid(rxv),
		.rx_char(rxc), .tx_data_out(tdo), .tx_data_oe(toe),
		.wake_out(wake), .irq_out(irq), .baud_count(bc));
	sst_master i_sst_master (.pclk(pclk), .tx_data_out(tdo),
		.shift_timing_pin(stp));
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic go(input int n, input int h, input logic [8:0] e);
		for (int k = 0; k < 20 && toe !== 1'b1; k++) @(posedge pclk);
		i_sst_master.xfer(n, h);
		chk("bits", 32'(e), 32'(i_sst_master.got));
	endtask : go
	task automatic t_regs;
		apb(0, 12'h004, 0);
		chk("tx", 0, rd);
		apb(1, 12'h008, 'hA5);
		apb(1, 12'h00C, 'h004);
		repeat (5) @(posedge pclk);
		chk("run", 1, 32'(bc != 8'h00));
		apb(1, 12'h008, 'hA5);
		@(posedge pclk);
		chk("cnt", 0, 32'(bc));
		apb(1, 12'h00C, 'h000);
		apb(0, 12'h008, 0);
		chk("brg", 32'h000000A5, rd);
		apb(1, 12'h000, 'h5A);
		apb(0, 12'h000, 0);
		chk("rx", 0, rd);
		apb(0, 12'h0FC, 0);
		chk("err", 1, 32'(er));
	endtask : t_regs
	task automatic t_rx;
		rxv <= 1'b1;
		rxc <= 9'h1C3;
		@(posedge pclk);
		rxv <= 1'b0;
		apb(0, 12'h000, 0);
		chk("rxd", 32'h000000C3, rd);
		apb(0, 12'h010, 0);
		chk("rx9", 1, 32'(rd[3]));
	endtask : t_rx
	task automatic t_tx;
		apb(1, 12'h00C, 'h003);
		apb(1, 12'h004, 'h05A);
		repeat (4) @(posedge pclk);
		chk("off", 0, 32'(toe));
		apb(1, 12'h00C, 'h04B);
		repeat (2) @(posedge pclk);
		chk("continuous_rx_enable", 0, 32'(toe));
		apb(1, 12'h00C, 'h143);
		repeat (2) @(posedge pclk);
		chk("analog_pin_select", 0, 32'(toe));
		apb(1, 12'h00C, 'h047);
		repeat (2) @(posedge pclk);
		chk("clock_source_select", 0, 32'(toe));
		apb(1, 12'h00C, 'h043);
		go(8, 2, 9'h05A);
		apb(1, 12'h00C, 'h0E3);
		apb(1, 12'h004, 'h03C);
		go(9, 4, 9'h13C);
	endtask : t_tx
	task automatic t_sleep;
		apb(1, 12'h00C, 'h043);
		apb(1, 12'h014, 'h003);
		apb(1, 12'h004, 'h0A1);
		repeat (2) @(posedge pclk);
		apb(1, 12'h004, 'h0B2);
		apb(1, 12'h018, 'h001);
		apb(0, 12'h010, 0);
		chk("st", 32'h00000006, 32'(rd[2:0]));
		chk("wk", 0, 32'(woke));
		go(8, 2, 9'h0A1);
		chk("wk", 1, 32'(woke));
		apb(0, 12'h010, 0);
		chk("st", 32'h00000005, 32'(rd[2:0]));
		chk("irq", 0, 32'(irq));
		apb(1, 12'h014, 'h007);
		@(posedge pclk);
		chk("irq", 1, 32'(irq));
		go(8, 3, 9'h0B2);
	endtask : t_sleep
	task automatic test_done;
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		{pclk, presetn, psel, penable, pwrite, rxv, woke} = 7'h00;
		{paddr, pwdata, rxc} = 53'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_rx;
		t_tx;
		t_sleep;
		test_done;
	end
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule : sst_tx_bench
`default_nettype wire
